// ===== tcs_pkg.sv
// Purpose: Shared types and constants of the transfer cycle sequencer.
// Assumes: One system clock; TCS_INTOP_STATES is in bus states (clock cycles), the other constants are encodings or counts.
// Notes:   Space and descriptor fields travel as packed structs.
package tcs_pkg;

  // ****************************************************************
  // Target space and transfer size encodings
  // ****************************************************************
  localparam logic [1:0] TCS_KIND_MEM    = 2'h0;
  localparam logic [1:0] TCS_KIND_PERIPH = 2'h1;
  localparam logic [1:0] TCS_KIND_EXT    = 2'h2;

  localparam logic [1:0] TCS_WIDTH_8  = 2'h0;
  localparam logic [1:0] TCS_WIDTH_16 = 2'h1;
  localparam logic [1:0] TCS_WIDTH_32 = 2'h2;

  localparam logic [1:0] TCS_SIZE_BYTE = 2'h0;
  localparam logic [1:0] TCS_SIZE_WORD = 2'h1;
  localparam logic [1:0] TCS_SIZE_LONG = 2'h2;

  // ****************************************************************
  // Access counts, internal-operation states and block maximum
  // ****************************************************************
  localparam logic [2:0] TCS_VEC_ACC       = 3'h1;
  localparam logic [2:0] TCS_INFO_FULL_ACC = 3'h4;
  localparam logic [2:0] TCS_INFO_SHRT_ACC = 3'h3;
  localparam logic [2:0] TCS_WB_FREE_ACC   = 3'h3;
  localparam logic [2:0] TCS_WB_ONE_ACC    = 3'h2;
  localparam logic [2:0] TCS_WB_BOTH_ACC   = 3'h1;
  localparam logic [2:0] TCS_SPLIT3_ACC    = 3'h3;
  localparam logic [2:0] TCS_SPLIT2_ACC    = 3'h2;
  localparam logic [2:0] TCS_ALIGN_ACC     = 3'h1;
  localparam logic [5:0] TCS_INTOP_STATES  = 6'h01;
  localparam logic [8:0] TCS_BLOCK_MAX     = 9'h100;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    TCS_OP_INFO = 2'h0,
    TCS_OP_BYTE = 2'h1,
    TCS_OP_WORD = 2'h2,
    TCS_OP_LONG = 2'h3
  } tcs_op_e;

  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] width;
    logic       three_state;
    logic [2:0] wait_m;
  } tcs_space_s;

  typedef struct packed {
    logic       full_addr;
    logic       src_fixed;
    logic       dst_fixed;
    logic       block_mode;
    logic [1:0] size;
    logic [1:0] src_lsb;
    logic [1:0] dst_lsb;
    logic [7:0] block_size_counter;
    logic       chain_enable_bit;
    tcs_space_s src_space;
    tcs_space_s dst_space;
  } tcs_desc_s;

endpackage

// ===== tcs_state_cost.sv
// Purpose: States taken by one bus access for a given target and operation.
// Assumes: wait_m is the external wait count inserted by the bus controller.
// Notes:   Pure combinational lookup.
`timescale 1ns/1ps
`default_nettype none
module tcs_state_cost
  import tcs_pkg::*;
(
  input  wire tcs_space_s space_i,
  input  wire tcs_op_e    op_i,
  output logic [5:0]      cost_o
);

  logic [5:0] m1;
  logic [5:0] m2;
  logic [5:0] m4;

  assign m1 = {3'h0, space_i.wait_m};
  assign m2 = {2'h0, space_i.wait_m, 1'b0};
  assign m4 = {1'b0, space_i.wait_m, 2'h0};

  always_comb begin
    cost_o = 6'h01;
    case (space_i.kind)
      TCS_KIND_MEM: begin
        cost_o = 6'h01;
      end
      TCS_KIND_PERIPH: begin
        case (op_i)
          TCS_OP_WORD: cost_o = (space_i.width == TCS_WIDTH_8) ? 6'h04 : 6'h02;
          TCS_OP_LONG: cost_o = (space_i.width == TCS_WIDTH_8)  ? 6'h08 :
                                (space_i.width == TCS_WIDTH_16) ? 6'h04 : 6'h02;
          default:     cost_o = 6'h02;
        endcase
      end
      TCS_KIND_EXT: begin
        if (space_i.width == TCS_WIDTH_8) begin
          case (op_i)
            TCS_OP_BYTE: cost_o = space_i.three_state ? 6'h03 + m1 : 6'h02;
            TCS_OP_WORD: cost_o = space_i.three_state ? 6'h04 + m2 : 6'h04;
            default:     cost_o = space_i.three_state ? 6'h0C + m4 : 6'h08;
          endcase
        end else begin
          case (op_i)
            TCS_OP_BYTE: cost_o = space_i.three_state ? 6'h03 + m1 : 6'h02;
            TCS_OP_WORD: cost_o = space_i.three_state ? 6'h03 + m1 : 6'h02;
            default:     cost_o = space_i.three_state ? 6'h06 + m2 : 6'h04;
          endcase
        end
      end
      default: cost_o = 6'h01;
    endcase
  end

endmodule
`default_nettype wire

// ===== tcs_sequencer.sv
// Purpose: Bus-ownership and state-accounting sequencer of an interrupt-activated
//          transfer controller.
// Assumes: The arbiter holds the grant while bus_req_o stays high; desc_i shows the
//          transfer information of the current set when an information read ends.
// Notes:   Each access lasts as many states as its target costs.
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer
  import tcs_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             act_req_i,
  input  wire logic             info_skip_i,
  input  wire logic [2:0]       cpu_priority_level_i,
  input  wire logic [2:0]       controller_priority_level_i,
  input  wire tcs_space_s       info_space_i,
  input  wire tcs_desc_s        desc_i,
  input  wire logic             bus_grant_i,
  output logic                  bus_req_o,
  output logic                  acc_start_o,
  output logic [3:0]            acc_phase_o,
  output logic                  busy_o,
  output logic                  pending_o,
  output logic                  done_o,
  output logic [CNT_W-1:0]      exec_states_o
);

  // ****************************************************************
  // State encoding
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_REQ   = 4'h1,
    ST_VEC   = 4'h2,
    ST_INFO  = 4'h3,
    ST_DRD   = 4'h4,
    ST_DWR   = 4'h5,
    ST_WB    = 4'h6,
    ST_INTOP = 4'h7,
    ST_REL   = 4'h8
  } tcs_state_e;

  tcs_state_e      state_ff;
  tcs_state_e      nxt_state;
  tcs_state_e      after_ff;
  tcs_state_e      nxt_after;
  tcs_desc_s       desc_ff;
  logic            skip_ff;
  logic            pend_ff;
  logic [5:0]      st_cnt_ff;
  logic [2:0]      acc_idx_ff;
  logic [8:0]      elem_ff;
  logic [CNT_W-1:0] exec_ff;
  logic            done_ff;

  logic            start;
  logic            bus_phase;
  logic            active;
  logic [5:0]      cost;
  logic [5:0]      phase_cost;
  logic [2:0]      acc_total;
  logic            acc_last_state;
  logic            phase_end;
  logic [8:0]      block_p;
  tcs_space_s      cost_space;
  tcs_op_e         cost_op;

  // ****************************************************************
  // Activation and priority
  // ****************************************************************
  assign start = pend_ff && (state_ff == ST_IDLE) &&
                 (controller_priority_level_i >= cpu_priority_level_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
    end else if (ce_i) begin
      if (act_req_i) begin
        pend_ff <= 1'b1;
      end else if (start) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Per-phase access count and state cost
  // ****************************************************************
  function automatic logic [2:0] data_count(input logic [1:0] size, input logic [1:0] lsb);
    logic [2:0] n;
    n = TCS_ALIGN_ACC;
    if (size == TCS_SIZE_LONG && lsb[0]) begin
      n = TCS_SPLIT3_ACC;
    end else if ((size == TCS_SIZE_WORD && lsb[0]) ||
                 (size == TCS_SIZE_LONG && lsb == 2'h2)) begin
      n = TCS_SPLIT2_ACC;
    end
    return n;
  endfunction

  function automatic tcs_op_e size_op(input logic [1:0] size);
    tcs_op_e o;
    o = TCS_OP_BYTE;
    case (size)
      TCS_SIZE_WORD: o = TCS_OP_WORD;
      TCS_SIZE_LONG: o = TCS_OP_LONG;
      default:       o = TCS_OP_BYTE;
    endcase
    return o;
  endfunction

  assign block_p = (desc_ff.block_size_counter == 8'h00) ? TCS_BLOCK_MAX :
                   {1'b0, desc_ff.block_size_counter};

  always_comb begin
    acc_total  = TCS_ALIGN_ACC;
    cost_space = info_space_i;
    cost_op    = TCS_OP_INFO;
    case (state_ff)
      ST_VEC: begin
        acc_total = TCS_VEC_ACC;
      end
      ST_INFO: begin
        acc_total = desc_i.full_addr ? TCS_INFO_FULL_ACC : TCS_INFO_SHRT_ACC;
      end
      ST_WB: begin
        if (desc_ff.src_fixed && desc_ff.dst_fixed) begin
          acc_total = TCS_WB_BOTH_ACC;
        end else if (desc_ff.src_fixed || desc_ff.dst_fixed) begin
          acc_total = TCS_WB_ONE_ACC;
        end else begin
          acc_total = TCS_WB_FREE_ACC;
        end
      end
      ST_DRD: begin
        acc_total  = data_count(desc_ff.size, desc_ff.src_lsb);
        cost_space = desc_ff.src_space;
        cost_op    = size_op(desc_ff.size);
      end
      ST_DWR: begin
        acc_total  = data_count(desc_ff.size, desc_ff.dst_lsb);
        cost_space = desc_ff.dst_space;
        cost_op    = size_op(desc_ff.size);
      end
      default: begin
        acc_total = TCS_ALIGN_ACC;
      end
    endcase
  end

  tcs_state_cost u_cost (
    .space_i (cost_space),
    .op_i    (cost_op),
    .cost_o  (cost)
  );

  assign phase_cost     = (state_ff == ST_INTOP) ? TCS_INTOP_STATES : cost;
  assign acc_last_state = (st_cnt_ff == phase_cost - 6'h01);
  assign phase_end      = acc_last_state && (acc_idx_ff == acc_total - 3'h1);

  assign bus_phase = (state_ff == ST_VEC) || (state_ff == ST_INFO) || (state_ff == ST_DRD) ||
                     (state_ff == ST_DWR) || (state_ff == ST_WB);
  assign active    = bus_phase || (state_ff == ST_INTOP);

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_after = after_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_REQ;
          nxt_after = info_skip_i ? ST_DRD : ST_VEC;
        end
      end
      ST_REQ: begin
        if (bus_grant_i) begin
          nxt_state = after_ff;
        end
      end
      ST_VEC: begin
        if (phase_end) begin
          nxt_state = ST_REL;
          nxt_after = ST_INFO;
        end
      end
      ST_INFO: begin
        if (phase_end) begin
          nxt_state = ST_REL;
          nxt_after = ST_DRD;
        end
      end
      ST_DRD: begin
        if (phase_end) begin
          nxt_state = ST_DWR;
        end
      end
      ST_DWR: begin
        if (phase_end) begin
          nxt_state = ST_REL;
          nxt_after = (elem_ff > 9'h001) ? ST_DRD : ST_WB;
        end
      end
      ST_WB: begin
        if (phase_end) begin
          nxt_state = ST_REL;
          if (desc_ff.chain_enable_bit) begin
            nxt_after = skip_ff ? ST_DRD : ST_INFO;
          end else begin
            nxt_after = skip_ff ? ST_IDLE : ST_INTOP;
          end
        end
      end
      ST_INTOP: begin
        if (phase_end) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_REL: begin
        if (after_ff == ST_IDLE || after_ff == ST_INTOP) begin
          nxt_state = after_ff;
        end else begin
          nxt_state = ST_REQ;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      after_ff <= ST_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
    end
  end

  // ****************************************************************
  // Descriptor capture
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      desc_ff <= '0;
      skip_ff <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        skip_ff <= info_skip_i;
        if (info_skip_i) begin
          desc_ff <= desc_i;
        end
      end else if (state_ff == ST_INFO && phase_end) begin
        desc_ff <= desc_i;
      end else if (state_ff == ST_WB && phase_end && skip_ff && desc_ff.chain_enable_bit) begin
        desc_ff <= desc_i;
      end
    end
  end

  // ****************************************************************
  // Access and state counters
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_cnt_ff  <= 6'h00;
      acc_idx_ff <= 3'h0;
    end else if (ce_i) begin
      if (!active || phase_end) begin
        st_cnt_ff  <= 6'h00;
        acc_idx_ff <= 3'h0;
      end else if (acc_last_state) begin
        st_cnt_ff  <= 6'h00;
        acc_idx_ff <= acc_idx_ff + 3'h1;
      end else begin
        st_cnt_ff <= st_cnt_ff + 6'h01;
      end
    end
  end

  // Element counter of a block: one single transfer per element.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      elem_ff <= 9'h001;
    end else if (ce_i) begin
      if (state_ff == ST_REQ && bus_grant_i && after_ff == ST_DRD && elem_ff == 9'h000) begin
        elem_ff <= desc_ff.block_mode ? block_p : 9'h001;
      end else if (state_ff == ST_DWR && phase_end) begin
        elem_ff <= elem_ff - 9'h001;
      end else if (state_ff == ST_IDLE) begin
        elem_ff <= 9'h000;
      end
    end
  end

  // Every state spent in an access phase is counted once.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      exec_ff <= '0;
      done_ff <= 1'b0;
    end else if (ce_i) begin
      done_ff <= 1'b0;
      if (start) begin
        exec_ff <= '0;
      end else if (active) begin
        exec_ff <= exec_ff + 1'b1;
      end
      if (state_ff != ST_IDLE && nxt_state == ST_IDLE) begin
        done_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus_req_o     = (state_ff == ST_REQ) || bus_phase;
  assign acc_start_o   = active && (st_cnt_ff == 6'h00);
  assign acc_phase_o   = state_ff;
  assign busy_o        = (state_ff != ST_IDLE);
  assign pending_o     = pend_ff;
  assign done_o        = done_ff;
  assign exec_states_o = exec_ff;

endmodule
`default_nettype wire

// ===== tcs_sequencer_props.sv
// Purpose: Port-level timing checks of the transfer cycle sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Phase codes follow the acc_phase_o encoding.
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       act_req_i,
  input wire logic       info_skip_i,
  input wire logic [2:0] cpu_priority_level_i,
  input wire logic [2:0] controller_priority_level_i,
  input wire logic       bus_grant_i,
  input wire logic       bus_req_o,
  input wire logic       acc_start_o,
  input wire logic [3:0] acc_phase_o,
  input wire logic       busy_o,
  input wire logic       pending_o,
  input wire logic       done_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  logic busy_q_ff;
  logic skip_q_ff;
  logic skip_run_ff;
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // Remembers whether the running activation skipped its information read.
  always_ff @(posedge ref_clk_i) begin
    busy_q_ff <= busy_o;
    skip_q_ff <= info_skip_i;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      skip_run_ff <= 1'h0;
    else if (busy_o && !busy_q_ff)
      skip_run_ff <= skip_q_ff;
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  // The internal operation runs after the bus has been offered back, so it needs no grant.
  AST_ACC_NEEDS_GRANT: assert property
    (acc_start_o && acc_phase_o != 4'h7 |-> bus_grant_i && bus_req_o)
    else $error("access started without grant");
  AST_INTOP_NO_BUS: assert property (acc_phase_o == 4'h7 |-> !bus_req_o)
    else $error("bus still requested during internal operation");
  AST_GRANT_STARTS_ACC: assert property
    (acc_phase_o == 4'h1 && bus_grant_i && ce_i |=> acc_start_o)
    else $error("grant seen but no access started");
  AST_START_REQUESTS: assert property ($rose(busy_o) |-> bus_req_o && acc_phase_o == 4'h1)
    else $error("activation did not request the bus");
  AST_LOW_PRIO_HOLDS: assert property
    (!busy_o && controller_priority_level_i < cpu_priority_level_i |=> !busy_o)
    else $error("started below processor priority");
  AST_REL_ONE_CYCLE: assert property
    (acc_phase_o == 4'h8 && ce_i |-> !bus_req_o ##1 acc_phase_o != 4'h8)
    else $error("release not a single cycle");
  AST_INFO_UNBROKEN: assert property
    (acc_phase_o == 4'h3 && ce_i |=> acc_phase_o inside {4'h3, 4'h8})
    else $error("information read broken");
  AST_WB_UNBROKEN: assert property
    (acc_phase_o == 4'h6 && ce_i |=> acc_phase_o inside {4'h6, 4'h8})
    else $error("writeback broken");
  AST_VEC_THEN_REL: assert property
    (acc_phase_o == 4'h2 && ce_i |=> acc_phase_o inside {4'h2, 4'h8})
    else $error("vector read not followed by release");
  AST_SKIP_NO_FETCH: assert property
    (skip_run_ff && busy_o |-> !(acc_phase_o inside {4'h2, 4'h3, 4'h7}))
    else $error("fetch phase in a skipped activation");
  AST_PEND_SET: assert property (act_req_i && ce_i |=> pending_o)
    else $error("request not held pending");
  AST_DONE_PULSE: assert property (done_o && ce_i |=> !done_o)
    else $error("done longer than one cycle");
  COV_SKIP: cover property ($rose(busy_o) ##1 skip_run_ff);
  COV_WB_REL: cover property (acc_phase_o == 4'h6 ##1 acc_phase_o == 4'h8);
  COV_HELD: cover property (pending_o && !busy_o ##4 pending_o && !busy_o);
endmodule
bind tcs_sequencer tcs_sequencer_props i_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .act_req_i(act_req_i),
  .info_skip_i(info_skip_i), .cpu_priority_level_i(cpu_priority_level_i),
  .controller_priority_level_i(controller_priority_level_i), .bus_grant_i(bus_grant_i),
  .bus_req_o(bus_req_o), .acc_start_o(acc_start_o), .acc_phase_o(acc_phase_o),
  .busy_o(busy_o), .pending_o(pending_o), .done_o(done_o)
);
`default_nettype wire

// ===== tcs_arb_model.sv
// Purpose: Bus arbiter on the far side of the sequencer.
// Assumes: Grant is held while the request stays high.
// Notes:   The grant trails the request by lag_i + 1 cycles.
`timescale 1ns/1ps
`default_nettype none
module tcs_arb_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [1:0] lag_i,
  output logic            grant_o
);
  logic [1:0] wait_ff;
  // ****************************************************************
  // Grant timing
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      wait_ff <= 2'h0;
      grant_o <= 1'h0;
    end else if (wait_ff == lag_i) begin
      grant_o <= 1'h1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== transfer_cycle_sequencer_tb_top.sv
// Purpose: Self-checking bench of the transfer cycle sequencer.
// Assumes: Arbiter model on the bus side; stimulus at rising edges.
// Notes:   Access and state counts are checked once per activation.
`timescale 1ns/1ps
`default_nettype none
module transfer_cycle_sequencer_tb_top import tcs_pkg::*;;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        act = 1'h0;
  logic        ce = 1'h1;
  logic        skip = 1'h0;
  logic [2:0]  cpu_p = 3'h0;
  logic [2:0]  ctl_p = 3'h0;
  logic [1:0]  lag = 2'h0;
  tcs_space_s  isp = '0;
  tcs_desc_s   desc = '0;
  tcs_space_s  mem;
  logic        grant;
  logic        req;
  logic        acc_start;
  logic        busy;
  logic        pending;
  logic        done;
  logic [3:0]  phase;
  logic [15:0] exec;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n_acc = 0;
  tcs_sequencer i_dut (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .act_req_i(act),
    .info_skip_i(skip), .cpu_priority_level_i(cpu_p), .controller_priority_level_i(ctl_p),
    .info_space_i(isp), .desc_i(desc), .bus_grant_i(grant), .bus_req_o(req),
    .acc_start_o(acc_start), .acc_phase_o(phase), .busy_o(busy), .pending_o(pending),
    .done_o(done), .exec_states_o(exec));
  tcs_arb_model i_arb (.clk_i(clk), .rst_i(rst), .req_i(req), .lag_i(lag), .grant_o(grant));
  always #20 clk = ~clk;
  // Counts bus accesses of one activation.
  always @(posedge clk) begin
    if (act)
      n_acc <= 0;
    else if (acc_start && phase != 4'h7)
      n_acc <= n_acc + 1;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic tcs_space_s sp(input logic [1:0] k, input logic [1:0] w,
                                    input logic t, input logic [2:0] m);
    sp = '{k, w, t, m};
  endfunction
  task automatic stop_test;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic compare_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: count %0h, wanted %0h", $time, got, exp);
    end
  endtask
  task automatic compare_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic kick(input logic sk);
    skip <= sk;
    act <= 1'h1;
    @(posedge clk);
    act <= 1'h0;
  endtask
  // Waits for done, dropping the chain bit once the first writeback shows.
  task automatic run(input logic [15:0] na, input logic [15:0] ns);
    int k;
    k = 0;
    while (done !== 1'h1 && k < 4000) begin
      @(posedge clk);
      k++;
      if (phase === 4'h6)
        desc.chain_enable_bit <= 1'h0;
    end
    if (k >= 4000)
      miscompares++;
    compare_val(n_acc[15:0], na);
    compare_val(exec, ns);
    skip <= 1'h0;
    @(posedge clk);
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    mem = sp(TCS_KIND_MEM, TCS_WIDTH_32, 1'h0, 3'h0);
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    isp <= sp(TCS_KIND_EXT, TCS_WIDTH_8, 1'h0, 3'h0);
    desc <= '{1'h1, 1'h0, 1'h0, 1'h0, TCS_SIZE_BYTE, 2'h0, 2'h0, 8'h01, 1'h0, mem, mem};
    kick(1'h0);
    run(16'h000A, 16'h0043);
    isp <= mem;
    lag <= 2'h1;
    desc <= '{1'h0, 1'h1, 1'h0, 1'h0, TCS_SIZE_WORD, 2'h1, 2'h0, 8'h01, 1'h0,
              sp(TCS_KIND_PERIPH, TCS_WIDTH_8, 1'h0, 3'h0), mem};
    kick(1'h0);
    // A low clock enable must freeze the pending activation in idle.
    ce <= 1'h0;
    repeat (4) @(posedge clk);
    compare_bit(busy, 1'h0);
    compare_bit(req, 1'h0);
    compare_bit(pending, 1'h1);
    ce <= 1'h1;
    run(16'h0009, 16'h0010);
    isp <= sp(TCS_KIND_EXT, TCS_WIDTH_8, 1'h0, 3'h0);
    desc <= '{1'h0, 1'h1, 1'h1, 1'h1, TCS_SIZE_LONG, 2'h2, 2'h1, 8'h02, 1'h0,
              sp(TCS_KIND_EXT, TCS_WIDTH_16, 1'h1, 3'h3), mem};
    kick(1'h0);
    run(16'h000F, 16'h005F);
    isp <= mem;
    ctl_p <= 3'h1;
    cpu_p <= 3'h3;
    desc <= '{1'h1, 1'h0, 1'h0, 1'h0, TCS_SIZE_BYTE, 2'h0, 2'h0, 8'h01, 1'h0,
              sp(TCS_KIND_PERIPH, TCS_WIDTH_16, 1'h0, 3'h0),
              sp(TCS_KIND_EXT, TCS_WIDTH_8, 1'h1, 3'h5)};
    kick(1'h1);
    repeat (6) @(posedge clk);
    compare_bit(pending, 1'h1);
    compare_bit(req, 1'h0);
    cpu_p <= 3'h0;
    run(16'h0005, 16'h000D);
    isp <= sp(TCS_KIND_EXT, TCS_WIDTH_16, 1'h1, 3'h7);
    lag <= 2'h2;
    desc <= '{1'h1, 1'h0, 1'h0, 1'h0, TCS_SIZE_BYTE, 2'h0, 2'h0, 8'h01, 1'h1, mem, mem};
    kick(1'h0);
    run(16'h0013, 16'h0131);
    stop_test();
  end
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
